// file: core/asc_pkg.sv
// Package for the asynchronous serial controller: register map, field positions, resets.
// Assumes a single 20 MHz clock and an 8-bit parallel host port with a 3-bit address.
`default_nettype none
package asc_pkg;

    localparam logic [2:0] ADR_DATA     = 3'h0;
    localparam logic [2:0] ADR_MASK     = 3'h1;
    localparam logic [2:0] ADR_CAUSE    = 3'h2;
    localparam logic [2:0] ADR_FORMAT   = 3'h3;
    localparam logic [2:0] ADR_MODEM    = 3'h4;
    localparam logic [2:0] ADR_LSTATE   = 3'h5;
    localparam logic [2:0] ADR_MSTATE   = 3'h6;
    localparam logic [2:0] ADR_SCRATCH  = 3'h7;

    localparam int FMT_DIV_ACCESS = 7;
    localparam int FMT_BREAK      = 6;
    localparam int FMT_STICK      = 5;
    localparam int FMT_EVEN       = 4;
    localparam int FMT_PAR_EN     = 3;
    localparam int FMT_STOP2      = 2;

    localparam int MOD_OUT2 = 3;
    localparam int MOD_LOOP = 4;

    localparam logic [2:0] CAUSE_NONE = 3'h1;
    localparam logic [2:0] CAUSE_LINE = 3'h6;
    localparam logic [2:0] CAUSE_RXD  = 3'h4;
    localparam logic [2:0] CAUSE_THRE = 3'h2;
    localparam logic [2:0] CAUSE_MDM  = 3'h0;

    localparam logic [7:0]  RST_REG8   = 8'h00;
    localparam logic [15:0] RST_DIVISOR = 16'h000C;
    localparam logic [3:0]  OVERSAMPLE  = 4'hF;
    localparam logic [3:0]  MID_SAMPLE  = 4'h7;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] adr;
        logic [7:0] wdata;
    } asc_host_t;

    typedef struct packed {
        logic overrun;
        logic parity;
        logic framing;
        logic brk;
    } asc_err_t;

endpackage

`default_nettype wire

// file: core/asc_top.sv
// Asynchronous serial controller: host registers, baud divider, transmitter, receiver.
// Assumes host strobes are one-cycle pulses synchronous to CLK; serial and modem
// inputs are already synchronous, modem inputs active high at these ports.
// Functional notes
// [RULE_01] Software keeps line speed at or below 19200.
// [RULE_02] Divider by 16-bit divisor gives 16x tick.
// [RULE_03] Mask holds four enables; upper nibble reads zero.
// [RULE_04] Masks gate interrupt only, status still updates.
// [RULE_05] Priority: line, rx data, tx empty, modem.
// [RULE_06] Cause read freezes highest pending cause.
// [RULE_07] Cause codes 001,110,100,010,000.
// [RULE_08] Bit0 high when idle; bits 7-3 zero.
// [RULE_09] Each cause clears on its own access.
// [RULE_10] Divisor access bit remaps low two addresses.
// [RULE_11] Break bit forces serial output spacing.
// [RULE_12] Stick parity sends fixed parity value.
// [RULE_13] Even select picks even count of ones.
// [RULE_14] Parity bit after data, before stop.
// [RULE_15] Stop bits: one, one-and-half, or two.
// [RULE_16] Format bits 1:0 select 5-8 data bits.
// [RULE_17] Modem bits drive DTR, RTS, OUT1; 7-5 zero.
// [RULE_18] OUT2 gates interrupt to host.
// [RULE_19] Loopback ties transmitter to receiver internally.
// [RULE_20] Loopback interrupts work, modem from control bits.
// [RULE_21] Line state flag layout, bit 7 zero.
// [RULE_22] Loopback maps control bits to modem state.
// [RULE_23] Holding-empty sets on transfer, clears on write.
// [RULE_24] Overrun sets on overwrite, clears on read.
// [RULE_25] Data-ready sets on receive, clears on read.
// [RULE_26] Receiver samples bit centre with 16x tick.
// [RULE_27] Reset clears controls; cause reads none pending.
`timescale 1ns/100ps
`default_nettype none

module asc_top (
    input  wire logic       CLK,      // 20 MHz clock
    input  wire logic       RST_N,    // Synchronous reset, active low
    input  wire logic       WR,       // Register write strobe
    input  wire logic       RD,       // Register read strobe
    input  wire logic [2:0] ADR,      // Register address
    input  wire logic [7:0] WDATA,    // Write data
    output logic      [7:0] RDATA,    // Read data, valid the cycle after RD
    input  wire logic       RXD,      // Serial input, high is marking
    input  wire logic       CTS,      // Clear to send, active high
    input  wire logic       DSR,      // Data set ready, active high
    input  wire logic       DCD,      // Carrier detect, active high
    input  wire logic       RI,       // Ring indicator, active high
    output logic            TXD,      // Serial output, high is marking
    output logic            DTR,      // Terminal ready, active high
    output logic            RTS,      // Request to send, active high
    output logic            OUT1,     // Auxiliary output 1, active high
    output logic            OUT2,     // Auxiliary output 2, active high
    output logic            IRQ       // Interrupt to host, active high
);

    asc_pkg::asc_host_t host;
    assign host = '{wr: WR, rd: RD, adr: ADR, wdata: WDATA};

    logic [7:0]  div_lo, div_hi, mask, fmt, mctl, scratch, rx_buffer_reg, tx_holding_reg;
    logic [15:0] baud_cnt;
    logic        tick;
    logic        thre, tsr_busy, data_ready;
    asc_pkg::asc_err_t err;
    logic [3:0]  msr_delta;
    logic [3:0]  mdm_now, mdm_prev;
    logic [2:0]  cause_held;
    logic        cause_frozen;
    logic        thre_int;

    wire dla   = fmt[asc_pkg::FMT_DIV_ACCESS];
    wire loop  = mctl[asc_pkg::MOD_LOOP];
    wire wr_dat = host.wr && host.adr == asc_pkg::ADR_DATA && !dla;   // RULE_10
    wire rd_dat = host.rd && host.adr == asc_pkg::ADR_DATA && !dla;   // RULE_10
    wire rd_lsr = host.rd && host.adr == asc_pkg::ADR_LSTATE;
    wire rd_msr = host.rd && host.adr == asc_pkg::ADR_MSTATE;
    wire rd_iir = host.rd && host.adr == asc_pkg::ADR_CAUSE;
    wire wr_div = host.wr && dla && (host.adr == asc_pkg::ADR_DATA
                                     || host.adr == asc_pkg::ADR_MASK);

    // Writable registers.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mask    <= asc_pkg::RST_REG8;   // RULE_27
            fmt     <= asc_pkg::RST_REG8;   // RULE_27
            mctl    <= asc_pkg::RST_REG8;   // RULE_27
            scratch <= asc_pkg::RST_REG8;
            div_lo  <= asc_pkg::RST_DIVISOR[7:0];
            div_hi  <= asc_pkg::RST_DIVISOR[15:8];
        end else if (host.wr) begin
            unique case (host.adr)
                asc_pkg::ADR_DATA:    if (dla) div_lo <= host.wdata;   // RULE_10
                asc_pkg::ADR_MASK:    if (dla) div_hi <= host.wdata;
                                      else mask <= {4'h0, host.wdata[3:0]};   // RULE_03
                asc_pkg::ADR_FORMAT:  fmt <= host.wdata;
                asc_pkg::ADR_MODEM:   mctl <= {3'h0, host.wdata[4:0]};   // RULE_17
                asc_pkg::ADR_SCRATCH: scratch <= host.wdata;
                default: ;
            endcase
        end
    end

    // Baud divider: a write to either latch reloads the counter at once.
    always_ff @(posedge CLK) begin
        if (!RST_N || wr_div) begin
            baud_cnt <= 16'h0001;
            tick     <= 1'b0;
        end else if (baud_cnt >= {div_hi, div_lo}) begin   // RULE_02
            baud_cnt <= 16'h0001;
            tick     <= 1'b1;
        end else begin
            baud_cnt <= baud_cnt + 16'h0001;
            tick     <= 1'b0;
        end
    end

    wire [3:0] nbits = {2'h0, fmt[1:0]} + 4'h5;   // RULE_16
    function automatic logic par_of(input logic [7:0] d, input logic [7:0] f);
        logic p;
        p = ^(d & (8'hFF >> (3 - f[1:0])));
        if (f[asc_pkg::FMT_STICK]) par_of = !f[asc_pkg::FMT_EVEN];   // RULE_12
        else par_of = f[asc_pkg::FMT_EVEN] ? p : !p;   // RULE_13
    endfunction

    // Transmitter: one 16-tick period per bit, half stop counted in ticks.
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
        TX_PAR  = 5'b01000, TX_STOP  = 5'b10000
    } asc_tx_t;
    asc_tx_t tx_st;
    logic [7:0] tsr;
    logic [3:0] tx_tk, tx_bit;
    logic [4:0] tx_stop_tk;
    logic       tx_line;
    wire [4:0] stop_len = !fmt[asc_pkg::FMT_STOP2] ? 5'd15 :
                          (fmt[1:0] == 2'b00) ? 5'd23 : 5'd31;   // RULE_15

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tx_st <= TX_IDLE; tsr <= 8'h00; tx_tk <= 4'h0; tx_bit <= 4'h0;
            tx_stop_tk <= 5'h00; tx_line <= 1'b1; tsr_busy <= 1'b0;
        end else if (tx_st == TX_IDLE) begin
            if (!thre) begin
                tsr <= tx_holding_reg; tx_st <= TX_START; tsr_busy <= 1'b1; tx_tk <= 4'h0;
            end
        end else if (tick) begin
            tx_tk <= tx_tk + 4'h1;
            unique case (tx_st)
                TX_START: begin tx_line <= 1'b0;
                    if (tx_tk == asc_pkg::OVERSAMPLE) begin tx_st <= TX_DATA; tx_bit <= 4'h0; end
                end
                TX_DATA: begin tx_line <= tsr[tx_bit[2:0]];
                    if (tx_tk == asc_pkg::OVERSAMPLE) begin
                        tx_bit <= tx_bit + 4'h1;
                        if (tx_bit + 4'h1 == nbits)
                            tx_st <= fmt[asc_pkg::FMT_PAR_EN] ? TX_PAR : TX_STOP;   // RULE_14
                        tx_stop_tk <= 5'h00;
                    end
                end
                TX_PAR: begin tx_line <= par_of(tsr, fmt);   // RULE_14
                    if (tx_tk == asc_pkg::OVERSAMPLE) tx_st <= TX_STOP;
                end
                TX_STOP: begin tx_line <= 1'b1; tx_stop_tk <= tx_stop_tk + 5'h01;
                    if (tx_stop_tk == stop_len) begin tx_st <= TX_IDLE; tsr_busy <= 1'b0; end
                end
                default: ;
            endcase
        end
    end

    // Holding register; empty flag sets on transfer to shifter, clears on write.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            thre <= 1'b1; tx_holding_reg <= 8'h00;
        end else if (wr_dat) begin
            thre <= 1'b0; tx_holding_reg <= host.wdata;   // RULE_23
        end else if (tx_st == TX_IDLE && !thre) begin
            thre <= 1'b1;   // RULE_23
        end
    end

    // Receiver, fed internally by the shifter in loopback.
    wire rx_in = loop ? tx_line : RXD;   // RULE_19
    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
    } asc_rx_t;
    asc_rx_t rx_st;
    logic [3:0] rx_tk, rx_bit;
    logic [7:0] rx_sh;
    logic       rx_par_bad, rx_all0, rx_done;
    logic       rx_fe;
    wire [3:0] rx_total = nbits + {3'h0, fmt[asc_pkg::FMT_PAR_EN]};

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rx_st <= RX_IDLE; rx_tk <= 4'h0; rx_bit <= 4'h0; rx_sh <= 8'h00;
            rx_par_bad <= 1'b0; rx_all0 <= 1'b0; rx_done <= 1'b0; rx_fe <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                rx_tk <= rx_tk + 4'h1;
                unique case (rx_st)
                    RX_IDLE: if (!rx_in) begin rx_st <= RX_START; rx_tk <= 4'h1; end
                    RX_START: if (rx_tk == asc_pkg::MID_SAMPLE) begin   // RULE_26
                        rx_tk <= 4'h0;
                        if (rx_in) rx_st <= RX_IDLE;
                        else begin rx_st <= RX_DATA; rx_bit <= 4'h0; rx_sh <= 8'h00;
                                   rx_all0 <= 1'b1; end
                    end
                    RX_DATA: if (rx_tk == asc_pkg::OVERSAMPLE) begin   // RULE_26
                        rx_bit <= rx_bit + 4'h1;
                        if (rx_in) rx_all0 <= 1'b0;
                        if (rx_bit < nbits) rx_sh[rx_bit[2:0]] <= rx_in;
                        else rx_par_bad <= rx_in != par_of(rx_sh, fmt);   // RULE_13
                        if (rx_bit + 4'h1 == rx_total) rx_st <= RX_STOP;
                        if (rx_bit == 4'h0) rx_par_bad <= 1'b0;
                    end
                    RX_STOP: if (rx_tk == asc_pkg::OVERSAMPLE) begin
                        rx_fe <= !rx_in; rx_done <= 1'b1; rx_st <= RX_IDLE;
                        if (rx_in) rx_all0 <= 1'b0;
                    end
                    default: ;
                endcase
            end
        end
    end

    // Line status flags; events win over the read that clears them.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rx_buffer_reg <= 8'h00; data_ready <= 1'b0; err <= '0;
        end else begin
            if (rd_lsr) err <= '0;   // RULE_24
            if (rd_dat) data_ready <= 1'b0;   // RULE_25
            if (rx_done) begin
                rx_buffer_reg <= rx_sh; data_ready <= 1'b1;   // RULE_25
                if (data_ready && !rd_dat) err.overrun <= 1'b1;   // RULE_24
                if (rx_par_bad && fmt[asc_pkg::FMT_PAR_EN]) err.parity <= 1'b1;
                if (rx_fe) err.framing <= 1'b1;
                if (rx_all0) err.brk <= 1'b1;
            end
        end
    end
    wire [7:0] line_state = {1'b0, thre && !tsr_busy, thre, err.brk, err.framing,
                      err.parity, err.overrun, data_ready};   // RULE_21

    // Modem state, from control bits in loopback.
    always_comb begin
        if (loop) mdm_now = {mctl[3], mctl[2], mctl[0], mctl[1]};   // RULE_22
        else mdm_now = {DCD, RI, DSR, CTS};
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mdm_prev <= 4'h0; msr_delta <= 4'h0;
        end else begin
            mdm_prev <= mdm_now;   // RULE_04
            for (int i = 0; i < 4; i++) begin
                if (i == 2) begin
                    if (mdm_prev[2] && !mdm_now[2]) msr_delta[i] <= 1'b1;   // RULE_20
                    else if (rd_msr) msr_delta[i] <= 1'b0;
                end else if (mdm_prev[i] != mdm_now[i]) msr_delta[i] <= 1'b1;
                else if (rd_msr) msr_delta[i] <= 1'b0;   // RULE_09
            end
        end
    end
    wire [7:0] modem_inputs_state = {mdm_now, msr_delta[3], msr_delta[2], msr_delta[1], msr_delta[0]};

    // Transmit-empty cause: set when holding empties, cleared by cause read or write.
    always_ff @(posedge CLK) begin
        if (!RST_N) thre_int <= 1'b0;
        else if (tx_st == TX_IDLE && !thre && !wr_dat) thre_int <= 1'b1;
        else if (wr_dat || (rd_iir && cause_held == asc_pkg::CAUSE_THRE)) thre_int <= 1'b0;   // RULE_09
        else if (host.wr && host.adr == asc_pkg::ADR_MASK && !dla && host.wdata[1]
                 && !mask[1] && thre) thre_int <= 1'b1;
    end

    logic [2:0] next_cause;
    always_comb begin
        if (mask[2] && |err) next_cause = asc_pkg::CAUSE_LINE;   // RULE_05
        else if (mask[0] && data_ready) next_cause = asc_pkg::CAUSE_RXD;
        else if (mask[1] && thre_int) next_cause = asc_pkg::CAUSE_THRE;
        else if (mask[3] && |msr_delta) next_cause = asc_pkg::CAUSE_MDM;
        else next_cause = asc_pkg::CAUSE_NONE;   // RULE_07
    end

    // Cause is frozen from a read until that cause is no longer pending.
    wire held_live = (cause_held == asc_pkg::CAUSE_LINE && |err) ||
                     (cause_held == asc_pkg::CAUSE_RXD && data_ready) ||
                     (cause_held == asc_pkg::CAUSE_THRE && thre_int) ||
                     (cause_held == asc_pkg::CAUSE_MDM && |msr_delta);
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cause_held <= asc_pkg::CAUSE_NONE; cause_frozen <= 1'b0;   // RULE_27
        end else if (rd_iir && !cause_frozen) begin
            cause_held <= next_cause;   // RULE_06
            cause_frozen <= next_cause != asc_pkg::CAUSE_NONE;
        end else if (cause_frozen && !held_live) begin
            cause_frozen <= 1'b0; cause_held <= next_cause;
        end else if (!cause_frozen) cause_held <= next_cause;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) RDATA <= 8'h00;
        else if (host.rd) begin
            unique case (host.adr)
                asc_pkg::ADR_DATA:    RDATA <= dla ? div_lo : rx_buffer_reg;
                asc_pkg::ADR_MASK:    RDATA <= dla ? div_hi : mask;
                asc_pkg::ADR_CAUSE:   RDATA <= {5'h00, cause_frozen ? cause_held : next_cause};   // RULE_08
                asc_pkg::ADR_FORMAT:  RDATA <= fmt;
                asc_pkg::ADR_MODEM:   RDATA <= mctl;
                asc_pkg::ADR_LSTATE:  RDATA <= line_state;
                asc_pkg::ADR_MSTATE:  RDATA <= modem_inputs_state;
                default:              RDATA <= scratch;
            endcase
        end
    end

    // Output pins; in loopback TXD, DTR, RTS, OUT1 and OUT2 are parked inactive, IRQ still follows OUT2.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            TXD <= 1'b1; DTR <= 1'b0; RTS <= 1'b0; OUT1 <= 1'b0; OUT2 <= 1'b0; IRQ <= 1'b0;
        end else begin
            TXD  <= loop ? 1'b1 : (fmt[asc_pkg::FMT_BREAK] ? 1'b0 : tx_line);   // RULE_11
            DTR  <= mctl[0] && !loop;   // RULE_17
            RTS  <= mctl[1] && !loop;   // RULE_17
            OUT1 <= mctl[2] && !loop;   // RULE_17
            OUT2 <= mctl[3] && !loop;
            IRQ  <= mctl[asc_pkg::MOD_OUT2] && next_cause != asc_pkg::CAUSE_NONE;   // RULE_18
        end
    end

    a_irq_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        !mctl[asc_pkg::MOD_OUT2] |=> !IRQ) else $error("irq without out2");   // RULE_18
    a_break_line: assert property (@(posedge CLK) disable iff (!RST_N)
        fmt[asc_pkg::FMT_BREAK] && !loop |=> !TXD) else $error("break not spacing");   // RULE_11
    a_loop_txd: assert property (@(posedge CLK) disable iff (!RST_N)
        loop |=> TXD && !DTR && !RTS) else $error("loop pins active");   // RULE_19
    a_dr_set: assert property (@(posedge CLK) disable iff (!RST_N)
        rx_done |=> data_ready) else $error("data ready missing");   // RULE_25
    a_ovr_set: assert property (@(posedge CLK) disable iff (!RST_N)
        rx_done && data_ready && !rd_dat |=> err.overrun) else $error("overrun missing");   // RULE_24
    a_thre_clr: assert property (@(posedge CLK) disable iff (!RST_N)
        wr_dat |=> !thre) else $error("thre not cleared");   // RULE_23
    a_mask_high: assert property (@(posedge CLK) disable iff (!RST_N)
        mask[7:4] == 4'h0 && mctl[7:5] == 3'h0) else $error("reserved bits set");   // RULE_03
    a_line_first: assert property (@(posedge CLK) disable iff (!RST_N)
        mask[2] && |err |-> next_cause == asc_pkg::CAUSE_LINE) else $error("priority");   // RULE_05
    c_rx_char: cover property (@(posedge CLK) disable iff (!RST_N) rx_done);
    c_loop_irq: cover property (@(posedge CLK) disable iff (!RST_N) loop && IRQ);
    c_frozen: cover property (@(posedge CLK) disable iff (!RST_N) cause_frozen && rd_iir);

endmodule // asc_top

`default_nettype wire

// file: dv/asc_modem_model.sv
// Far-side serial line and modem model for the serial controller bench.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module asc_modem_model #(
    parameter int BIT_CYC = 16
) (
    input  wire logic       clk,  // Bench clock
    input  wire logic       txd,  // Serial data from the controller
    output var  logic       rxd,  // Serial data to the controller
    output var  logic [3:0] mdm   // DCD, RI, DSR, CTS, active high
);
    initial begin
        rxd = 1'b1;
        mdm = 4'h0;
    end
    // One edge passes so the controller has latched the change before the bench reads.
    task automatic lines(input logic [3:0] m);
        mdm = m;
        @(posedge clk);
        #1;
    endtask
    // The line idles marking and every bit lasts the programmed period.
    task automatic send(input logic [7:0] d, input int n);
        rxd = 1'b0;
        repeat (BIT_CYC) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd = d[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        rxd = 1'b1;
        repeat (BIT_CYC) @(posedge clk);
    endtask
    // Samples n bits after the start bit, each at its centre.
    task automatic grab(input int n, output logic [9:0] v);
        int t;
        v = '0;
        t = 0;
        while (txd !== 1'b0 && t < 4000) begin
            @(posedge clk);
            #1;
            t++;
        end
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            #1 v[i] = txd;
        end
    endtask
endmodule // asc_modem_model
`default_nettype wire

// file: dv/asc_top_tb_top.sv
// Self-checking bench for the serial controller registers and serial path.
// Assumes divisor 1, so one serial bit lasts 16 clocks.
`timescale 1ns/100ps
`default_nettype none
module asc_top_tb_top;
    logic       clk, rst_n, wr, rd, rxd, txd, dtr, rts, out1, out2, irq;
    logic [2:0] adr;
    logic [7:0] wdata, rdata, v;
    logic [3:0] mdm;
    logic [9:0] fr;
    int         n_mismatch = 0;
    int         checks = 0;
    logic [7:0] fmts [4] = '{8'h1B, 8'h0B, 8'h3B, 8'h2B};
    logic       pars [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    asc_top dut_u (.CLK(clk), .RST_N(rst_n), .WR(wr), .RD(rd), .ADR(adr),
        .WDATA(wdata), .RDATA(rdata), .RXD(rxd), .CTS(mdm[0]), .DSR(mdm[1]),
        .DCD(mdm[3]), .RI(mdm[2]), .TXD(txd), .DTR(dtr), .RTS(rts),
        .OUT1(out1), .OUT2(out2), .IRQ(irq));
    asc_modem_model #(.BIT_CYC(16)) modem_u (.clk(clk), .txd(txd), .rxd(rxd), .mdm(mdm));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic chk(input logic [9:0] g, input logic [9:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // An idle cycle closes every access so a strobe is never raised twice at once.
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        wr = 1'b1;
        adr = a;
        wdata = d;
        @(posedge clk);
        #1 wr = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        rd = 1'b1;
        adr = a;
        @(posedge clk);
        #1 rd = 1'b0;
        @(posedge clk);
        #1 v = rdata;
        chk({2'b0, v & m}, {2'b0, e});
    endtask
    task automatic wrap_up;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        adr = 3'h0;
        wdata = 8'h00;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        rchk(asc_pkg::ADR_MASK, 8'h00);
        rchk(asc_pkg::ADR_FORMAT, 8'h00);
        rchk(asc_pkg::ADR_MODEM, 8'h00);
        rchk(asc_pkg::ADR_CAUSE, 8'h01);
        rchk(asc_pkg::ADR_LSTATE, 8'h60);
        wreg(asc_pkg::ADR_MASK, 8'hFF);
        rchk(asc_pkg::ADR_MASK, 8'h0F);
        chk({9'h0, irq}, 10'h0);
        rchk(asc_pkg::ADR_CAUSE, 8'h02);
        rchk(asc_pkg::ADR_CAUSE, 8'h01);
        wreg(asc_pkg::ADR_FORMAT, 8'h83);
        wreg(asc_pkg::ADR_DATA, 8'h01);
        wreg(asc_pkg::ADR_MASK, 8'h00);
        rchk(asc_pkg::ADR_DATA, 8'h01);
        rchk(asc_pkg::ADR_MASK, 8'h00);
        wreg(asc_pkg::ADR_FORMAT, 8'h03);
        rchk(asc_pkg::ADR_MASK, 8'h0F);
        wreg(asc_pkg::ADR_MODEM, 8'hEB);
        rchk(asc_pkg::ADR_MODEM, 8'h0B);
        chk({6'h0, out2, out1, rts, dtr}, 10'h00B);
        wreg(asc_pkg::ADR_MASK, 8'h00);
        wreg(asc_pkg::ADR_MASK, 8'h0F);
        chk({9'h0, irq}, 10'h1);
        modem_u.send(8'h3C, 8);
        rchk(asc_pkg::ADR_CAUSE, 8'h04);
        rchk(asc_pkg::ADR_DATA, 8'h3C);
        rchk(asc_pkg::ADR_CAUSE, 8'h02);
        modem_u.send(8'h11, 8);
        modem_u.send(8'h22, 8);
        rchk(asc_pkg::ADR_CAUSE, 8'h06);
        rchk(asc_pkg::ADR_LSTATE, 8'h63);
        rchk(asc_pkg::ADR_LSTATE, 8'h61);
        rchk(asc_pkg::ADR_DATA, 8'h22);
        rchk(asc_pkg::ADR_CAUSE, 8'h01);
        modem_u.lines(4'h1);
        rchk(asc_pkg::ADR_CAUSE, 8'h00);
        rchk(asc_pkg::ADR_MSTATE, 8'h11);
        rchk(asc_pkg::ADR_CAUSE, 8'h01);
        wreg(asc_pkg::ADR_MASK, 8'h00);
        modem_u.lines(4'h0);
        rchk(asc_pkg::ADR_MSTATE, 8'h01);
        chk({9'h0, irq}, 10'h0);
        for (int i = 0; i < 4; i++) begin
            wreg(asc_pkg::ADR_FORMAT, fmts[i]);
            fork
                modem_u.grab(10, fr);
                wreg(asc_pkg::ADR_DATA, 8'hA7);
            join
            chk(fr, {1'b1, pars[i], 8'hA7});
        end
        wreg(asc_pkg::ADR_FORMAT, 8'h00);
        fork
            modem_u.grab(6, fr);
            wreg(asc_pkg::ADR_DATA, 8'hA7);
        join
        chk(fr, 10'h027);
        repeat (20) @(posedge clk);
        #1 wreg(asc_pkg::ADR_FORMAT, 8'h07);
        fork
            modem_u.grab(10, fr);
            begin
                wreg(asc_pkg::ADR_DATA, 8'hA7);
                wreg(asc_pkg::ADR_DATA, 8'h00);
            end
        join
        chk(fr, {2'b11, 8'hA7});
        repeat (250) @(posedge clk);
        #1 wreg(asc_pkg::ADR_FORMAT, 8'h43);
        chk({9'h0, txd}, 10'h0);
        wreg(asc_pkg::ADR_FORMAT, 8'h03);
        chk({9'h0, txd}, 10'h1);
        wreg(asc_pkg::ADR_MODEM, 8'h1B);
        chk({5'h0, txd, out2, out1, rts, dtr}, 10'h010);
        rchk(asc_pkg::ADR_MSTATE, 8'hB0, 8'hF0);
        wreg(asc_pkg::ADR_DATA, 8'h5A);
        repeat (200) @(posedge clk);
        #1 rchk(asc_pkg::ADR_DATA, 8'h5A);
        wrap_up();
    end
endmodule // asc_top_tb_top
`default_nettype wire
